// [pcg_pkg.sv]
// shared constants and types for the peripheral clock gating block
`default_nettype none
package pcg_pkg;
	// ==========================================
	// bus and register map
	localparam int          PCG_AW          = 12;
	localparam int          PCG_DW          = 32;
	localparam logic [11:0] PCG_OFS_CFG     = 12'h060;
	localparam logic [11:0] PCG_OFS_RUN     = 12'h104;
	localparam logic [11:0] PCG_OFS_SLEEP   = 12'h114;
	localparam logic [11:0] PCG_OFS_DEEP    = 12'h124;
	// ==========================================
	// field layout and reset values
	localparam logic [31:0] PCG_GATE_WMASK  = 32'h0007_5033;
	localparam logic [31:0] PCG_GATE_RST    = 32'h0000_0000;
	localparam int          PCG_ACG_BIT     = 27;
	localparam logic [31:0] PCG_CFG_WMASK   = 32'h0800_0000;
	localparam logic [31:0] PCG_CFG_RST     = 32'h0000_0000;
	localparam logic [31:0] PCG_ZERO        = 32'h0000_0000;
	// ==========================================
	// controlled units: index -> gating bit position
	localparam int          PCG_NUNIT       = 9;
	localparam int          PCG_UIW         = 4;
	localparam int          PCG_UNIT_BIT [PCG_NUNIT] = '{0, 1, 4, 5, 12, 14, 16, 17, 18};
	// ==========================================
	// power modes
	typedef enum logic [1:0] {
		PCG_RUN,
		PCG_SLEEP,
		PCG_DEEP
	} pcg_mode_t;
endpackage
`default_nettype wire

// [pcg_gate_cell.sv]
// one unit's registered clock enable
`timescale 1ns/1ps
`default_nettype none
module pcg_gate_cell
	import pcg_pkg::*;
(
	input  wire logic clk,
	input  wire logic sys_rst,
	input  wire logic gate_on,
	output var  logic clk_en
);
	// ==========================================
	// enable flop: changes only on a clock edge, so no glitches reach the unit gate
	always_ff @(posedge clk) begin
		if (sys_rst) begin
			clk_en <= 1'b0;
		end else begin
			clk_en <= gate_on;
		end
	end
endmodule
`default_nettype wire

// [pcg_bus_guard.sv]
// answers peripheral accesses: grant when clocked, bus fault when gated
`timescale 1ns/1ps
`default_nettype none
module pcg_bus_guard
	import pcg_pkg::*;
#(
	parameter int NUNIT = PCG_NUNIT
)
(
	input  wire logic               clk,
	input  wire logic               sys_rst,
	input  wire logic               periph_req,
	input  wire logic [PCG_UIW-1:0] periph_unit,
	input  wire logic [NUNIT-1:0]   unit_clk_en,
	output var  logic               periph_ok,
	output var  logic               periph_fault
);
	logic live;

	// unit exists and currently has its clock
	always_comb begin
		live = 1'b0;
		if (32'(periph_unit) < NUNIT) begin
			live = unit_clk_en[periph_unit];
		end
	end

	// ==========================================
	// one-cycle answer; a gated unit never sees the access
	always_ff @(posedge clk) begin
		if (sys_rst) begin
			periph_ok    <= 1'b0;
			periph_fault <= 1'b0;
		end else begin
			periph_ok    <= periph_req && live;
			periph_fault <= periph_req && !live;
		end
	end
endmodule
`default_nettype wire

// [pcg_gate_ctrl.sv]
// peripheral clock gating control, group 1: registers, mode select, enables
`timescale 1ns/1ps
`default_nettype none
module pcg_gate_ctrl
	import pcg_pkg::*;
#(
	parameter int NUNIT = PCG_NUNIT
)
(
	input  wire logic               clk,
	input  wire logic               sys_rst,
	input  wire logic [PCG_AW-1:0]  addr,
	input  wire logic [PCG_DW-1:0]  wr_data,
	input  wire logic               wr_stb,
	input  wire logic               rd_stb,
	output var  logic [PCG_DW-1:0]  rd_data,
	input  wire logic               sleep_req,
	input  wire logic               deepsleep_req,
	input  wire logic               periph_req,
	input  wire logic [PCG_UIW-1:0] periph_unit,
	output var  logic               periph_ok,
	output var  logic               periph_fault,
	output var  logic [NUNIT-1:0]   unit_clk_en
);
	logic [PCG_DW-1:0] run_clock_gate_1_q;
	logic [PCG_DW-1:0] sleep_clock_gate_1_q;
	logic [PCG_DW-1:0] deepsleep_clock_gate_1_q;
	logic [PCG_DW-1:0] run_clock_config_q;
	logic [PCG_DW-1:0] active_gate;
	logic [PCG_DW-1:0] rd_data_d;
	logic              auto_gating_select;
	logic [NUNIT-1:0]  active_unit;
	logic [NUNIT-1:0]  run_unit;
	pcg_mode_t         mode_q;
	pcg_mode_t         mode_d;
	logic              hit_run;
	logic              hit_sleep;
	logic              hit_deep;
	logic              hit_cfg;
	logic              unit_live;

	// ==========================================
	// address decode
	assign hit_run   = (addr == PCG_OFS_RUN);
	assign hit_sleep = (addr == PCG_OFS_SLEEP);
	assign hit_deep  = (addr == PCG_OFS_DEEP);
	assign hit_cfg   = (addr == PCG_OFS_CFG);
	assign auto_gating_select = run_clock_config_q[PCG_ACG_BIT];

	// ==========================================
	// run-mode gating register; reserved bits masked off
	always_ff @(posedge clk) begin
		if (sys_rst) begin
			run_clock_gate_1_q <= PCG_GATE_RST;
		end else if (wr_stb && hit_run) begin
			run_clock_gate_1_q <= wr_data & PCG_GATE_WMASK;
		end
	end

	// sleep-mode gating register, same layout
	always_ff @(posedge clk) begin
		if (sys_rst) begin
			sleep_clock_gate_1_q <= PCG_GATE_RST;
		end else if (wr_stb && hit_sleep) begin
			sleep_clock_gate_1_q <= wr_data & PCG_GATE_WMASK;
		end
	end

	// deep-sleep gating register, same layout
	always_ff @(posedge clk) begin
		if (sys_rst) begin
			deepsleep_clock_gate_1_q <= PCG_GATE_RST;
		end else if (wr_stb && hit_deep) begin
			deepsleep_clock_gate_1_q <= wr_data & PCG_GATE_WMASK;
		end
	end

	// run clock configuration: only the auto gating bit is kept here
	always_ff @(posedge clk) begin
		if (sys_rst) begin
			run_clock_config_q <= PCG_CFG_RST;
		end else if (wr_stb && hit_cfg) begin
			run_clock_config_q <= wr_data & PCG_CFG_WMASK;
		end
	end

	// ==========================================
	// read mux; unmapped offsets read zero
	always_comb begin
		rd_data_d = PCG_ZERO;
		if (hit_run) begin
			rd_data_d = run_clock_gate_1_q;
		end else if (hit_sleep) begin
			rd_data_d = sleep_clock_gate_1_q;
		end else if (hit_deep) begin
			rd_data_d = deepsleep_clock_gate_1_q;
		end else if (hit_cfg) begin
			rd_data_d = run_clock_config_q;
		end
	end

	// read data stand only in the cycle after the strobe
	always_ff @(posedge clk) begin
		if (sys_rst) begin
			rd_data <= PCG_ZERO;
		end else if (rd_stb) begin
			rd_data <= rd_data_d;
		end else begin
			rd_data <= PCG_ZERO;
		end
	end

	// ==========================================
	// power mode: sleep requests only honoured with auto gating set
	always_comb begin
		mode_d = PCG_RUN;
		case (mode_q)
			PCG_RUN, PCG_SLEEP, PCG_DEEP: begin
				if (auto_gating_select && deepsleep_req) begin
					mode_d = PCG_DEEP;
				end else if (auto_gating_select && sleep_req) begin
					mode_d = PCG_SLEEP;
				end else begin
					mode_d = PCG_RUN;
				end
			end
			default: begin
				mode_d = PCG_RUN;
			end
		endcase
	end

	always_ff @(posedge clk) begin
		if (sys_rst) begin
			mode_q <= PCG_RUN;
		end else begin
			mode_q <= mode_d;
		end
	end

	// pick the register that governs the current mode
	always_comb begin
		case (mode_q)
			PCG_SLEEP: active_gate = sleep_clock_gate_1_q;
			PCG_DEEP:  active_gate = deepsleep_clock_gate_1_q;
			PCG_RUN:   active_gate = run_clock_gate_1_q;
			default:   active_gate = run_clock_gate_1_q;
		endcase
	end

	// ==========================================
	// one enable cell per unit, picked from its bit position
	for (genvar u = 0; u < NUNIT; u++) begin : g_unit
		assign active_unit[u] = active_gate[PCG_UNIT_BIT[u]];
		assign run_unit[u]    = run_clock_gate_1_q[PCG_UNIT_BIT[u]];
		pcg_gate_cell u_cell (
			.clk     (clk),
			.sys_rst (sys_rst),
			.gate_on (active_unit[u]),
			.clk_en  (unit_clk_en[u])
		);
	end

	// ==========================================
	// bus fault for accesses to unclocked units
	pcg_bus_guard #(
		.NUNIT (NUNIT)
	) u_guard (
		.clk          (clk),
		.sys_rst      (sys_rst),
		.periph_req   (periph_req),
		.periph_unit  (periph_unit),
		.unit_clk_en  (unit_clk_en),
		.periph_ok    (periph_ok),
		.periph_fault (periph_fault)
	);

	// ==========================================
	// assertion helper: target unit exists and is clocked
	always_comb begin
		unit_live = 1'b0;
		if (32'(periph_unit) < NUNIT) begin
			unit_live = unit_clk_en[periph_unit];
		end
	end

	// ==========================================
	// assertions
	a_reset_clears: assert property (@(posedge clk)
		sys_rst |=> (run_clock_gate_1_q == PCG_GATE_RST)
			&& (sleep_clock_gate_1_q == PCG_GATE_RST)
			&& (deepsleep_clock_gate_1_q == PCG_GATE_RST)
			&& (unit_clk_en == '0) ##1 (unit_clk_en == '0))
		else $error("gating state not cleared by reset");

	a_clk_follows: assert property (@(posedge clk) disable iff (sys_rst)
		$past(!sys_rst) |-> unit_clk_en == $past(active_unit))
		else $error("unit enable does not follow active gate bit");

	a_gated_fault: assert property (@(posedge clk) disable iff (sys_rst)
		periph_req && !unit_live |=> periph_fault && !periph_ok)
		else $error("access to gated unit not faulted");

	a_live_grant: assert property (@(posedge clk) disable iff (sys_rst)
		periph_req && unit_live |=> periph_ok && !periph_fault)
		else $error("access to clocked unit not granted");

	a_timer_bits: assert property (@(posedge clk) disable iff (sys_rst)
		wr_stb && hit_run |=> run_clock_gate_1_q[18:16] == $past(wr_data[18:16]))
		else $error("timer enables not stored at 18:16");

	a_twowire_bits: assert property (@(posedge clk) disable iff (sys_rst)
		wr_stb && hit_run |=> run_clock_gate_1_q[14] == $past(wr_data[14])
			&& run_clock_gate_1_q[12] == $past(wr_data[12]))
		else $error("two-wire enables not stored at 14 and 12");

	a_sync_bits: assert property (@(posedge clk) disable iff (sys_rst)
		wr_stb && hit_run |=> run_clock_gate_1_q[5:4] == $past(wr_data[5:4]))
		else $error("sync serial enables not stored at 5:4");

	a_uart_bits: assert property (@(posedge clk) disable iff (sys_rst)
		wr_stb && hit_run |=> run_clock_gate_1_q[1:0] == $past(wr_data[1:0]))
		else $error("uart enables not stored at 1:0");

	a_resv_zero: assert property (@(posedge clk) disable iff (sys_rst)
		rd_stb && (hit_run || hit_sleep || hit_deep)
			|=> (rd_data & ~PCG_GATE_WMASK) == PCG_ZERO)
		else $error("reserved gating bits read nonzero");

	a_mode_pick: assert property (@(posedge clk) disable iff (sys_rst)
		mode_q == PCG_SLEEP |-> active_unit == g_sleep_units(sleep_clock_gate_1_q))
		else $error("sleep mode not using sleep gating register");

	a_acg_off_run: assert property (@(posedge clk) disable iff (sys_rst)
		!auto_gating_select |=> mode_q == PCG_RUN)
		else $error("sleep gating used without auto gating");

	a_sleep_read: assert property (@(posedge clk) disable iff (sys_rst)
		rd_stb && hit_sleep |=> rd_data == $past(sleep_clock_gate_1_q) ##1 rd_data == PCG_ZERO
			|| $past(rd_stb))
		else $error("sleep gating register read wrong");

	a_run_read: assert property (@(posedge clk) disable iff (sys_rst)
		rd_stb && hit_run |=> rd_data == $past(run_clock_gate_1_q))
		else $error("run gating register read wrong");

	a_switch_time: assert property (@(posedge clk) disable iff (sys_rst)
		wr_stb && hit_run && mode_q == PCG_RUN ##1 mode_q == PCG_RUN
			|=> unit_clk_en == $past(run_unit))
		else $error("run write not applied to enables in two cycles");

	a_run_resv: assert property (@(posedge clk) disable iff (sys_rst)
		(run_clock_gate_1_q & ~PCG_GATE_WMASK) == PCG_ZERO)
		else $error("run gating register holds reserved bits");

	a_sleep_resv: assert property (@(posedge clk) disable iff (sys_rst)
		(sleep_clock_gate_1_q & ~PCG_GATE_WMASK) == PCG_ZERO)
		else $error("sleep gating register holds reserved bits");

	a_deep_resv: assert property (@(posedge clk) disable iff (sys_rst)
		(deepsleep_clock_gate_1_q & ~PCG_GATE_WMASK) == PCG_ZERO)
		else $error("deep-sleep gating register holds reserved bits");

	a_cfg_only_acg: assert property (@(posedge clk) disable iff (sys_rst)
		(run_clock_config_q & ~PCG_CFG_WMASK) == PCG_ZERO)
		else $error("clock config keeps more than the auto gating bit");

	a_sleep_store: assert property (@(posedge clk) disable iff (sys_rst)
		wr_stb && hit_sleep |=> sleep_clock_gate_1_q == ($past(wr_data) & PCG_GATE_WMASK))
		else $error("sleep gating register write not stored");

	a_deep_store: assert property (@(posedge clk) disable iff (sys_rst)
		wr_stb && hit_deep |=> deepsleep_clock_gate_1_q == ($past(wr_data) & PCG_GATE_WMASK))
		else $error("deep-sleep gating register write not stored");

	a_run_hold: assert property (@(posedge clk) disable iff (sys_rst)
		!(wr_stb && hit_run) |=> $stable(run_clock_gate_1_q))
		else $error("run gating register changed without a write");

	a_deep_wins: assert property (@(posedge clk) disable iff (sys_rst)
		auto_gating_select && deepsleep_req |=> mode_q == PCG_DEEP)
		else $error("deep sleep request not entering deep mode");

	a_sleep_entry: assert property (@(posedge clk) disable iff (sys_rst)
		auto_gating_select && sleep_req && !deepsleep_req |=> mode_q == PCG_SLEEP)
		else $error("sleep request not entering sleep mode");

	a_deep_pick: assert property (@(posedge clk) disable iff (sys_rst)
		mode_q == PCG_DEEP |-> active_gate == deepsleep_clock_gate_1_q)
		else $error("deep mode not using deep-sleep gating register");

	a_run_pick: assert property (@(posedge clk) disable iff (sys_rst)
		mode_q == PCG_RUN |-> active_gate == run_clock_gate_1_q)
		else $error("run mode not using run gating register");

	a_one_answer: assert property (@(posedge clk) disable iff (sys_rst)
		!(periph_ok && periph_fault))
		else $error("access both granted and faulted");

	a_quiet_idle: assert property (@(posedge clk) disable iff (sys_rst)
		!periph_req |=> !periph_ok && !periph_fault)
		else $error("access answer without a request");

	a_read_idle: assert property (@(posedge clk) disable iff (sys_rst)
		!rd_stb |=> rd_data == PCG_ZERO)
		else $error("read data not zero outside read cycle");

	// sleep-register view for the mode check
	function automatic logic [NUNIT-1:0] g_sleep_units(input logic [PCG_DW-1:0] r);
		logic [NUNIT-1:0] v;
		v = '0;
		for (int i = 0; i < NUNIT; i++) begin
			v[i] = r[PCG_UNIT_BIT[i]];
		end
		return v;
	endfunction

	// ==========================================
	// scenario covers
	c_sleep_clocked: cover property (@(posedge clk) disable iff (sys_rst)
		mode_q == PCG_SLEEP && unit_clk_en != '0);
	c_fault_seen: cover property (@(posedge clk) disable iff (sys_rst)
		periph_fault);
	c_write_read: cover property (@(posedge clk) disable iff (sys_rst)
		wr_stb && hit_run ##1 rd_stb && hit_run ##1 rd_data != PCG_ZERO);
	c_deep_entry: cover property (@(posedge clk) disable iff (sys_rst)
		mode_q == PCG_RUN ##1 mode_q == PCG_DEEP);
	c_grant_seen: cover property (@(posedge clk) disable iff (sys_rst)
		periph_ok);
endmodule
`default_nettype wire

// [pcg_periph_model.sv]
// model of the peripheral side: issues one-cycle bus accesses to controlled units
`timescale 1ns/1ps
`default_nettype none
module pcg_periph_model
	import pcg_pkg::*;
(
	input  wire logic               clk,
	input  wire logic               sys_rst,
	input  wire logic               go,
	input  wire logic [PCG_UIW-1:0] go_unit,
	output var  logic               periph_req,
	output var  logic [PCG_UIW-1:0] periph_unit
);
	// launch an access one cycle after the command; idle index keeps toggling
	always_ff @(posedge clk) begin
		if (sys_rst) begin
			periph_req  <= 1'b0;
			periph_unit <= '0;
		end else begin
			periph_req  <= go;
			periph_unit <= go ? go_unit : ~periph_unit;
		end
	end
endmodule
`default_nettype wire

// [pcg_gate_ctrl_tb.sv]
// self-checking bench for the peripheral clock gating control
`timescale 1ns/1ps
`default_nettype none
module pcg_gate_ctrl_tb
	import pcg_pkg::*;
;
	logic                 clk = 1'b0;
	logic                 sys_rst = 1'b1;
	logic [PCG_AW-1:0]    addr = '0;
	logic [PCG_DW-1:0]    wr_data = '0;
	logic                 wr_stb = 1'b0;
	logic                 rd_stb = 1'b0;
	logic                 sleep_req = 1'b0;
	logic                 deepsleep_req = 1'b0;
	logic                 go = 1'b0;
	logic [PCG_UIW-1:0]   go_unit = '0;
	logic                 periph_req;
	logic [PCG_UIW-1:0]   periph_unit;
	logic [PCG_DW-1:0]    rd_data;
	logic                 periph_ok;
	logic                 periph_fault;
	logic [PCG_NUNIT-1:0] unit_clk_en;
	logic                 rv = 1'b0;
	logic                 pv = 1'b0;
	logic [31:0]          rd_q [$];
	logic [31:0]          pq [$];
	logic [31:0]          r;
	logic [31:0]          s;
	logic [31:0]          d;
	int                   fail_count = 0;
	int                   check_count = 0;
	pcg_gate_ctrl dut (.clk(clk), .sys_rst(sys_rst), .addr(addr), .wr_data(wr_data), .wr_stb(wr_stb),
		.rd_stb(rd_stb), .rd_data(rd_data), .sleep_req(sleep_req), .deepsleep_req(deepsleep_req),
		.periph_req(periph_req), .periph_unit(periph_unit), .periph_ok(periph_ok),
		.periph_fault(periph_fault), .unit_clk_en(unit_clk_en));
	pcg_periph_model partner (.clk(clk), .sys_rst(sys_rst), .go(go), .go_unit(go_unit),
		.periph_req(periph_req), .periph_unit(periph_unit));
	// ==========================================
	// helpers
	task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
		check_count++;
		if (g !== e) begin
			fail_count++;
			$display("unexpected %s expected %h seen %h", n, e, g);
		end
	endtask
	task automatic results();
		if (fail_count == 0 && check_count > 0) begin
			$display("TEST PASSED");
		end else begin
			$display("TEST FAILED");
		end
		$finish;
	endtask
	function automatic logic [31:0] en_of(input logic [31:0] v);
		en_of = '0;
		for (int i = 0; i < PCG_NUNIT; i++) begin
			en_of[i] = v[PCG_UNIT_BIT[i]];
		end
	endfunction
	// op 0 idle, 1 write, 2 read with expected word e; one bus cycle each
	task automatic bus(input int op, input logic [11:0] a, input logic [31:0] v, input logic [31:0] e);
		addr    <= a;
		wr_data <= v;
		wr_stb  <= (op == 1);
		rd_stb  <= (op == 2);
		if (op == 2) rd_q.push_back(e);
		@(posedge clk);
	endtask
	task automatic idle(input int n);
		repeat (n) bus(0, 12'h000, 32'h0000_0000, 32'h0000_0000);
	endtask
	task automatic en_chk(input logic [31:0] v);
		@(negedge clk);
		chk("unit_clk_en", en_of(v), {23'h0, unit_clk_en});
		@(posedge clk);
	endtask
	// access every unit index plus one out of range, enables held at v
	task automatic access_all(input logic [31:0] v);
		logic [31:0] e;
		e = en_of(v);
		for (int u = 0; u <= PCG_NUNIT; u++) begin
			go      <= 1'b1;
			go_unit <= u[PCG_UIW-1:0];
			pq.push_back((u < PCG_NUNIT && e[u]) ? 32'h0000_0002 : 32'h0000_0001);
			@(posedge clk);
		end
		go <= 1'b0;
		idle(2);
	endtask
	// ==========================================
	// clock and watchdog
	initial begin
		forever #5 clk = ~clk;
	end
	initial begin
		repeat (20000) @(posedge clk);
		fail_count++;
		results();
	end
	// result monitor: answers appear the cycle after their request
	always @(posedge clk) begin
		rv <= rd_stb;
		pv <= periph_req;
	end
	always @(negedge clk) begin
		if (rv && rd_q.size() > 0) chk("rd_data", rd_q.pop_front(), rd_data);
		else if (!sys_rst) chk("rd_idle", 32'h0000_0000, rd_data);
		if (pv && pq.size() > 0) chk("periph", pq.pop_front(), {30'h0, periph_ok, periph_fault});
		else if (!sys_rst) chk("periph_idle", 32'h0000_0000, {30'h0, periph_ok, periph_fault});
	end
	// ==========================================
	// main sequence
	initial begin
		void'($urandom(32'h14cafb7f));
		repeat (3) @(posedge clk);
		sys_rst <= 1'b0;
		foreach (PCG_UNIT_BIT[i]) bus(2, PCG_OFS_RUN + 12'(i * 4), 32'h0, PCG_ZERO);
		bus(2, PCG_OFS_SLEEP, 32'h0, PCG_GATE_RST);
		bus(2, PCG_OFS_RUN, 32'h0, PCG_GATE_RST);
		bus(2, PCG_OFS_DEEP, 32'h0, PCG_GATE_RST);
		bus(2, PCG_OFS_CFG, 32'h0, PCG_CFG_RST);
		bus(1, PCG_OFS_RUN, 32'hffff_ffff, 32'h0);
		bus(2, PCG_OFS_RUN, 32'h0, PCG_GATE_WMASK);
		idle(1);
		en_chk(PCG_GATE_WMASK);
		access_all(PCG_GATE_WMASK);
		for (int k = 0; k < 4; k++) begin
			r = (k == 0) ? 32'h0000_0000 : $urandom();
			bus(1, PCG_OFS_RUN, r, 32'h0);
			bus(2, PCG_OFS_RUN, 32'h0, r & PCG_GATE_WMASK);
			idle(1);
			en_chk(r);
			access_all(r);
		end
		s = $urandom();
		d = $urandom();
		bus(1, PCG_OFS_SLEEP, s, 32'h0);
		bus(1, PCG_OFS_DEEP, d, 32'h0);
		bus(2, PCG_OFS_SLEEP, 32'h0, s & PCG_GATE_WMASK);
		bus(2, PCG_OFS_DEEP, 32'h0, d & PCG_GATE_WMASK);
		sleep_req <= 1'b1;
		idle(4);
		en_chk(r);
		bus(1, PCG_OFS_CFG, 32'hffff_ffff, 32'h0);
		bus(2, PCG_OFS_CFG, 32'h0, PCG_CFG_WMASK);
		idle(3);
		en_chk(s & PCG_GATE_WMASK);
		access_all(s & PCG_GATE_WMASK);
		deepsleep_req <= 1'b1;
		idle(4);
		en_chk(d & PCG_GATE_WMASK);
		access_all(d & PCG_GATE_WMASK);
		deepsleep_req <= 1'b0;
		sleep_req     <= 1'b0;
		idle(4);
		en_chk(r);
		sys_rst <= 1'b1;
		idle(3);
		sys_rst <= 1'b0;
		bus(2, PCG_OFS_RUN, 32'h0, PCG_GATE_RST);
		bus(2, PCG_OFS_SLEEP, 32'h0, PCG_GATE_RST);
		bus(2, PCG_OFS_CFG, 32'h0, PCG_CFG_RST);
		idle(1);
		en_chk(PCG_GATE_RST);
		idle(2);
		if (rd_q.size() != 0 || pq.size() != 0) fail_count++;
		results();
	end
endmodule
`default_nettype wire
